// *** include/dtc_pkg.sv ***
// Constants and carrier types for the on-die termination controller.
// Assumes one 250 MHz command clock and mode fields held static by the mode register logic.
package dtc_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    // Skew of the strength change in thousandths of a clock; the analog driver places it.
    localparam int TERM_CHANGE_SKEW_MIN_PERMILLE = 300;
    localparam int TERM_CHANGE_SKEW_NOM_PERMILLE = 500;
    localparam int TERM_CHANGE_SKEW_MAX_PERMILLE = 700;

    localparam int ASYNC_TERM_ON_TIME_PS    = 8000;
    localparam int ASYNC_TERM_OFF_TIME_PS   = 8000;
    localparam int REFRESH_CYCLE_TIME_PS    = 160000;
    localparam int PD_EXIT_DLL_DELAY_PS     = 24000;
    localparam int PD_ENTRY_CMD_DELAY_CK    = 1;

    localparam int ASYNC_ON_CYC  = (ASYNC_TERM_ON_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_OFF_CYC = (ASYNC_TERM_OFF_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RFC_CYC       = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int XPDLL_CYC     = (PD_EXIT_DLL_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CPDED_CYC     = PD_ENTRY_CMD_DELAY_CK;

    localparam int TERM_HOLD_MIN_SHORT         = 4;
    localparam int TERM_HOLD_MIN_LONG          = 6;
    localparam int WRITE_TO_NOM_EXTRA_CHOP4    = 4;
    localparam int WRITE_TO_NOM_EXTRA_BURST8   = 6;
    localparam int TERM_LATENCY_OFFSET         = 2;
    localparam int PD_TRANSITION_LEAD_OFFSET   = 1;

    localparam int DLY_DEPTH = 32;
    localparam int DLY_IDX_W = 5;
    localparam int CNT_W     = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

    typedef struct packed {
        logic wr;
        logic bc4;
        logic refresh;
    } dtc_cmd_type;

    typedef struct packed {
        logic [3:0] write_latency;
        logic [3:0] additive_latency;
        logic [2:0] nominal_termination_value;
        logic [1:0] write_termination_value;
        logic       pd_dll_freeze_bit;
    } dtc_mode_type;

    typedef enum logic [3:0] {
        ST_SYNC  = 4'b0001,
        ST_ENTRY = 4'b0010,
        ST_ASYNC = 4'b0100,
        ST_EXIT  = 4'b1000
    } dtc_state_type;

    function automatic logic [DLY_IDX_W-1:0] dtc_tap(input logic [DLY_IDX_W:0] cycles);
        logic [DLY_IDX_W:0] t;
        t = (cycles > 6'(TERM_LATENCY_OFFSET)) ? cycles - 6'(TERM_LATENCY_OFFSET) : 6'h00;
        return t[DLY_IDX_W-1:0];
    endfunction : dtc_tap

    function automatic logic [DLY_IDX_W:0] dtc_term_latency(input dtc_mode_type m);
        return 6'(m.write_latency) + 6'(m.additive_latency) - 6'(TERM_LATENCY_OFFSET);
    endfunction : dtc_term_latency

endpackage : dtc_pkg

// *** core/dtc_delay_line.sv ***
// Tapped shift register used to time termination events.
// Assumes the tap index stays below the depth; output stage index tap is read directly.
module dtc_delay_line
    import dtc_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [W-1:0]         din,
    input  wire logic [DLY_IDX_W-1:0] tap,
    output logic      [W-1:0]         dout
);

    logic [W-1:0] pipe_reg [DLY_DEPTH];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < DLY_DEPTH; i++)
            begin
                pipe_reg[i] <= '0;
            end
        end
        else
        begin
            pipe_reg[0] <= din;
            for (int i = 1; i < DLY_DEPTH; i++)
            begin
                pipe_reg[i] <= pipe_reg[i-1];
            end
        end
    end

    assign dout = pipe_reg[tap];

endmodule : dtc_delay_line

// *** core/dtc_term_ctrl.sv ***
// On-die termination control: pin timing, dynamic write strength and power-down modes.
// Assumes cmd comes from the device's command decoder on clk; the pin and CKE are asynchronous.
module dtc_term_ctrl
    import dtc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         odt_pin,
    input  wire logic         cke_pin,
    input  wire dtc_cmd_type  cmd,
    input  wire dtc_mode_type mode,
    input  wire logic         all_banks_idle,
    output logic              term_on,
    output logic              term_write_sel,
    output logic [2:0]        term_code,
    output logic              async_mode,
    output logic              trans_window
);

    logic          odt_s1_reg, odt_s2_reg, odt_s3_reg;
    logic          cke_s1_reg, cke_s2_reg, cke_s3_reg;
    dtc_cmd_type   cmd_d1_reg, cmd_d2_reg;
    dtc_state_type state_reg;
    logic [CNT_W-1:0] win_cnt_reg, rfc_cnt_reg;
    logic [2:0]    hold_cnt_reg;
    logic          freeze_pd_reg;
    logic          term_on_reg, term_write_sel_reg;
    logic [2:0]    term_code_reg;
    logic          use_async;
    logic          dyn_en;
    logic          cke_fall, cke_rise;
    logic [DLY_IDX_W:0]   lat;
    logic [DLY_IDX_W-1:0] odt_tap;
    logic          odt_dly;
    logic [1:0]    wr_dly;

    assign lat      = dtc_term_latency(mode);
    assign dyn_en   = |mode.write_termination_value;
    assign cke_fall = cke_s3_reg & ~cke_s2_reg;
    assign cke_rise = ~cke_s3_reg & cke_s2_reg;
    assign use_async = (state_reg == ST_ASYNC) || ((state_reg == ST_EXIT) && freeze_pd_reg);

    // Pins are synchronised; commands are delayed by the same two cycles to stay aligned.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            odt_s1_reg <= 1'b0;
            odt_s2_reg <= 1'b0;
            odt_s3_reg <= 1'b0;
            cke_s1_reg <= 1'b0;
            cke_s2_reg <= 1'b0;
            cke_s3_reg <= 1'b0;
            cmd_d1_reg <= '0;
            cmd_d2_reg <= '0;
        end
        else
        begin
            odt_s1_reg <= odt_pin;
            odt_s2_reg <= odt_s1_reg;
            odt_s3_reg <= odt_s2_reg;
            cke_s1_reg <= cke_pin;
            cke_s2_reg <= cke_s1_reg;
            cke_s3_reg <= cke_s2_reg;
            cmd_d1_reg <= cmd;
            cmd_d2_reg <= cmd_d1_reg;
        end
    end

    // The asynchronous path skips the additive latency and uses its own on and off times.
    always_comb
    begin
        if (use_async)
        begin
            odt_tap = term_on_reg ? dtc_tap(6'(ASYNC_OFF_CYC)) : dtc_tap(6'(ASYNC_ON_CYC));
        end
        else
        begin
            odt_tap = dtc_tap(lat);
        end
    end

    dtc_delay_line #(
        .W      (1)
    ) u_odt_dly (
        .clk    (clk),
        .resetn (resetn),
        .din    (odt_s2_reg),
        .tap    (odt_tap),
        .dout   (odt_dly)
    );

    dtc_delay_line #(
        .W      (2)
    ) u_wr_dly (
        .clk    (clk),
        .resetn (resetn),
        .din    ({cmd_d2_reg.wr & dyn_en, cmd_d2_reg.bc4}),
        .tap    (dtc_tap(lat)),
        .dout   (wr_dly)
    );

    // Only the pin path may switch termination on or off; writes change strength alone.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            term_on_reg <= 1'b0;
        end
        else
        begin
            term_on_reg <= odt_dly;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            term_write_sel_reg <= 1'b0;
            hold_cnt_reg       <= 3'h0;
        end
        else if (wr_dly[1])
        begin
            term_write_sel_reg <= 1'b1;
            hold_cnt_reg <= wr_dly[0] ? 3'(WRITE_TO_NOM_EXTRA_CHOP4)
                                      : 3'(WRITE_TO_NOM_EXTRA_BURST8);
        end
        else if (hold_cnt_reg != 3'h0)
        begin
            hold_cnt_reg <= hold_cnt_reg - 3'h1;
            if (hold_cnt_reg == 3'h1)
            begin
                term_write_sel_reg <= 1'b0;
            end
        end
    end

    // The flop launches the new strength at the latency edge; the driver centres it in the skew.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            term_code_reg <= 3'h0;
        end
        else if (!odt_dly)
        begin
            term_code_reg <= 3'h0;
        end
        else if (wr_dly[1] || (term_write_sel_reg && hold_cnt_reg != 3'h1))
        begin
            term_code_reg <= {1'b0, mode.write_termination_value};
        end
        else
        begin
            term_code_reg <= mode.nominal_termination_value;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rfc_cnt_reg <= '0;
        end
        else if (cmd_d2_reg.refresh)
        begin
            rfc_cnt_reg <= CNT_W'(RFC_CYC);
        end
        else if (rfc_cnt_reg != '0)
        begin
            rfc_cnt_reg <= rfc_cnt_reg - 8'h01;
        end
    end

    // Inside a window either timing is legal, so entry keeps sync and exit keeps async while freeze_pd_reg is set.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg     <= ST_SYNC;
            win_cnt_reg   <= '0;
            freeze_pd_reg <= 1'b0;
        end
        else
        begin
            if (win_cnt_reg != '0)
            begin
                win_cnt_reg <= win_cnt_reg - 8'h01;
            end
            unique case (state_reg)
                ST_SYNC:
                begin
                    if (cke_fall)
                    begin
                        state_reg     <= ST_ENTRY;
                        win_cnt_reg   <= CNT_W'(CPDED_CYC);
                        freeze_pd_reg <= all_banks_idle & ~mode.pd_dll_freeze_bit;
                    end
                end
                ST_ENTRY:
                begin
                    if (cke_rise)
                    begin
                        state_reg   <= ST_EXIT;
                        win_cnt_reg <= CNT_W'(XPDLL_CYC);
                    end
                    else if (win_cnt_reg <= 8'h01 && rfc_cnt_reg <= 8'h01)
                    begin
                        state_reg <= freeze_pd_reg ? ST_ASYNC : ST_SYNC;
                    end
                end
                ST_ASYNC:
                begin
                    if (cke_rise)
                    begin
                        state_reg   <= ST_EXIT;
                        win_cnt_reg <= CNT_W'(XPDLL_CYC);
                    end
                end
                ST_EXIT:
                begin
                    if (cke_fall)
                    begin
                        state_reg   <= ST_ENTRY;
                        win_cnt_reg <= CNT_W'(CPDED_CYC);
                    end
                    else if (win_cnt_reg <= 8'h01)
                    begin
                        state_reg <= ST_SYNC;
                    end
                end
            endcase
        end
    end

    assign term_on        = term_on_reg;
    assign term_write_sel = term_write_sel_reg;
    assign term_code      = term_code_reg;
    assign async_mode     = use_async;
    assign trans_window   = freeze_pd_reg && (state_reg == ST_ENTRY || state_reg == ST_EXIT);

    // Cycles since the synchronised pin last rose or fell, read only by the checks below.
    logic [CNT_W-1:0] age_on_reg, age_off_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            age_on_reg  <= CNT_MAX;
            age_off_reg <= CNT_MAX;
        end
        else
        begin
            age_on_reg  <= (odt_s2_reg && !odt_s3_reg) ? 8'h01
                         : (age_on_reg != CNT_MAX) ? age_on_reg + 8'h01 : age_on_reg;
            age_off_reg <= (!odt_s2_reg && odt_s3_reg) ? 8'h01
                         : (age_off_reg != CNT_MAX) ? age_off_reg + 8'h01 : age_off_reg;
        end
    end

    property p_wr_sel_burst8;
        @(posedge clk) disable iff (!resetn)
        (wr_dly == 2'b10) |=> term_write_sel [*6];
    endproperty
    a_wr_sel_burst8: assert property (p_wr_sel_burst8)
        else $error("write strength not held six cycles");

    property p_wr_sel_chop4;
        @(posedge clk) disable iff (!resetn)
        (wr_dly == 2'b11) |=> term_write_sel [*4] ##1 (!term_write_sel || $past(wr_dly[1], 4));
    endproperty
    a_wr_sel_chop4: assert property (p_wr_sel_chop4)
        else $error("chop write strength window wrong");

    property p_wr_sel_latency;
        @(posedge clk) disable iff (!resetn)
        (cmd_d2_reg.wr && dyn_en && $stable(mode) && lat == 6'd6) |-> ##6 term_write_sel;
    endproperty
    a_wr_sel_latency: assert property (p_wr_sel_latency)
        else $error("write strength not selected at latency");

    property p_nominal_code;
        @(posedge clk) disable iff (!resetn)
        (term_on && !term_write_sel && $stable(mode)) |-> term_code == mode.nominal_termination_value;
    endproperty
    a_nominal_code: assert property (p_nominal_code)
        else $error("nominal strength not applied");

    property p_sync_on_latency;
        @(posedge clk) disable iff (!resetn)
        ($rose(term_on) && state_reg == ST_SYNC && $stable(mode)) |-> age_on_reg == 8'(lat);
    endproperty
    a_sync_on_latency: assert property (p_sync_on_latency)
        else $error("termination on at wrong latency");

    property p_sync_off_latency;
        @(posedge clk) disable iff (!resetn)
        ($fell(term_on) && state_reg == ST_SYNC && $stable(mode)) |-> age_off_reg == 8'(lat);
    endproperty
    a_sync_off_latency: assert property (p_sync_off_latency)
        else $error("termination off at wrong latency");

    property p_entry_start;
        @(posedge clk) disable iff (!resetn)
        (state_reg == ST_SYNC && cke_fall) |=> state_reg == ST_ENTRY;
    endproperty
    a_entry_start: assert property (p_entry_start)
        else $error("entry window not opened");

    property p_refresh_extends;
        @(posedge clk) disable iff (!resetn)
        (state_reg == ST_ENTRY && rfc_cnt_reg > 8'h01) |=> state_reg inside {ST_ENTRY, ST_EXIT};
    endproperty
    a_refresh_extends: assert property (p_refresh_extends)
        else $error("entry window closed during refresh");

    property p_exit_start;
        @(posedge clk) disable iff (!resetn)
        (state_reg == ST_ASYNC && cke_rise) |=> state_reg == ST_EXIT ##1 async_mode;
    endproperty
    a_exit_start: assert property (p_exit_start)
        else $error("exit window not opened");

endmodule : dtc_term_ctrl

// *** sim/dtc_ctrl_model.sv ***
// Behavioural memory controller driving the termination block's pins, commands and mode fields.
// Assumes one bench process calls its tasks; each task acts at the next rising edge, except a lowering set_pin, which first waits out the hold spans.
module dtc_ctrl_model
    import dtc_pkg::*;
(
    input  wire logic    clk,
    output logic         odt_pin,
    output logic         cke_pin,
    output dtc_cmd_type  cmd,
    output dtc_mode_type mode,
    output logic         all_banks_idle
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt   = 0;
    int t_end = 0;

    initial
    begin
        odt_pin = 1'b0;
        cke_pin = 1'b1;
        cmd = '0;
        mode = '0;
        all_banks_idle = 1'b1;
    end

    always @(posedge clk) cnt <= cnt + 1;

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            cmd <= '0;
        end
    endtask : tick

    // Lowering waits until every hold span has run out, so a short request is stretched.
    task automatic set_pin(input logic v);
        do
        begin
            @(posedge clk);
            cmd <= '0;
        end
        while (!v && cnt < t_end);
        odt_pin <= v;
        if (v && cnt + TERM_HOLD_MIN_SHORT > t_end)
            t_end = cnt + TERM_HOLD_MIN_SHORT;
    endtask : set_pin

    task automatic write(input logic bc4);
        int h;
        h = bc4 ? TERM_HOLD_MIN_SHORT : TERM_HOLD_MIN_LONG;
        @(posedge clk);
        cmd <= '{wr: 1'b1, bc4: bc4, refresh: 1'b0};
        if (cnt + h > t_end)
            t_end = cnt + h;
    endtask : write

    // With the DLL off the write strength field is cleared, which disables dynamic switching.
    task automatic set_mode(input dtc_mode_type m, input logic dll_off, input logic idle);
        dtc_mode_type v;
        v = m;
        if (dll_off)
            v.write_termination_value = 2'b00;
        tick(1);
        mode <= v;
        all_banks_idle <= idle;
    endtask : set_mode

    // A refresh is a one-cycle command; the next task call clears it.
    task automatic refresh;
        @(posedge clk);
        cmd <= '{wr: 1'b0, bc4: 1'b0, refresh: 1'b1};
    endtask : refresh

    task automatic set_cke(input logic v);
        tick(1);
        cke_pin <= v;
    endtask : set_cke
endmodule : dtc_ctrl_model

// *** sim/tb.sv ***
// Self-checking bench for the termination controller: pin, write and power-down timing.
// Assumes the controller model drives every input but clk and resetn, which the bench drives, and outputs settle 1 ns after an edge.
module tb;
    import dtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic [31:0] cyc;
        logic [6:0]  vec;
    } dtc_note_type;

    logic         clk    = 1'b0;
    logic         resetn = 1'b0;
    logic [31:0]  cyc    = 32'h00000000;
    logic [31:0]  lfsr   = 32'h0001498c;
    logic [6:0]   prev;
    logic         odt_pin;
    logic         cke_pin;
    logic         all_banks_idle;
    logic         term_on;
    logic         term_write_sel;
    logic         async_mode;
    logic         trans_window;
    logic [2:0]   term_code;
    dtc_cmd_type  cmd;
    dtc_mode_type mode;
    dtc_mode_type m;
    dtc_note_type notes[$];
    dtc_note_type exp_note;
    int           lat;
    int           err_total = 0;
    int           n_checks  = 0;
    wire  [6:0]   vec = {async_mode, trans_window, term_on, term_write_sel, term_code};

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 32'h1;

    dtc_ctrl_model ctl (.clk(clk), .odt_pin(odt_pin), .cke_pin(cke_pin), .cmd(cmd),
        .mode(mode), .all_banks_idle(all_banks_idle));

    dtc_term_ctrl uut (.clk(clk), .resetn(resetn), .odt_pin(odt_pin), .cke_pin(cke_pin),
        .cmd(cmd), .mode(mode), .all_banks_idle(all_banks_idle), .term_on(term_on),
        .term_write_sel(term_write_sel), .term_code(term_code), .async_mode(async_mode),
        .trans_window(trans_window));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [38:0] got, input logic [38:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: seen %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Called at the drive edge, before the cycle counter has advanced.
    task automatic note(input int n, input logic [6:0] v);
        notes.push_back('{cyc: cyc + 32'(n + 1), vec: v});
    endtask : note

    task automatic new_mode(input logic [1:0] w, input logic frz, input logic idle);
        lfsr = lfsr_next(lfsr);
        m.write_latency = 4'h5 + 4'(lfsr[7:0] % 6);
        m.additive_latency = 4'(lfsr[9:8]);
        m.nominal_termination_value = 3'h1 + 3'(lfsr[15:8] % 7);
        m.write_termination_value = w;
        m.pd_dll_freeze_bit = frz;
        lat = int'(m.write_latency) + int'(m.additive_latency) - 2;
        ctl.set_mode(m, w == 2'h0, idle);
        ctl.tick(4);
    endtask : new_mode

    task automatic pin_on;
        ctl.set_pin(1'b1);
        note(lat + 2, {3'b001, 1'b0, m.nominal_termination_value});
    endtask : pin_on

    task automatic pin_off(input int wait_n);
        ctl.tick(wait_n);
        ctl.set_pin(1'b0);
        note(lat + 2, 7'h00);
        ctl.tick(lat + 6);
    endtask : pin_off

    // Pin changes stay well clear of both transition windows.
    // A refresh just before CKE falls stretches the entry window to the refresh cycle end.
    task automatic power_down(input logic frz, input logic idle, input logic rf);
        logic a;
        a = idle & ~frz;
        new_mode(2'h1, frz, idle);
        if (rf)
            ctl.refresh();
        ctl.set_cke(1'b0);
        if (a)
        begin
            note(3, 7'h20);
            note(rf ? RFC_CYC + 2 : 4, 7'h40);
        end
        ctl.tick(rf ? RFC_CYC + 8 : 8);
        ctl.set_pin(1'b1);
        note(a ? 2 + ASYNC_ON_CYC : lat + 2, {a, 2'b01, 1'b0, m.nominal_termination_value});
        ctl.tick(6);
        ctl.set_pin(1'b0);
        note(a ? 2 + ASYNC_OFF_CYC : lat + 2, {a, 6'h00});
        ctl.tick(lat + 6);
        ctl.set_cke(1'b1);
        if (a)
        begin
            note(3, 7'h60);
            note(3 + XPDLL_CYC, 7'h00);
        end
        ctl.tick(lat + 12);
    endtask : power_down

    // Every output change must match the oldest pending expectation, in cycle and value.
    always @(posedge clk)
    begin
        #1;
        if (!resetn)
            prev = vec;
        else if (vec !== prev)
        begin
            prev = vec;
            exp_note = (notes.size() > 0) ? notes.pop_front() : dtc_note_type'('1);
            check({cyc, vec}, exp_note);
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        ctl.tick(2);
        for (int i = 0; i < 4; i++)
        begin
            new_mode(2'h1, lfsr[3], lfsr[4]);
            pin_on();
            pin_off(int'(lfsr[2:0]));
        end
        for (int w = 1; w < 4; w++)
        begin
            for (int b = 0; b < 2; b++)
            begin
                new_mode(2'(w), lfsr[3], lfsr[4]);
                pin_on();
                ctl.write(b[0]);
                note(lat + 2, {4'b0011, 1'b0, 2'(w)});
                note(lat + 8 - 2 * b, {3'b001, 1'b0, m.nominal_termination_value});
                pin_off(6);
            end
        end
        // A chop write reloaded one cycle later by a burst write keeps the write strength.
        new_mode(2'h2, lfsr[3], lfsr[4]);
        pin_on();
        ctl.write(1'b1);
        note(lat + 2, {4'b0011, 3'h2});
        ctl.write(1'b0);
        note(lat + 8, {3'b001, 1'b0, m.nominal_termination_value});
        pin_off(6);
        // A cleared write field must leave the strength alone during a write.
        new_mode(2'h0, lfsr[3], lfsr[4]);
        pin_on();
        ctl.write(lfsr[5]);
        pin_off(6);
        // Frozen with refresh, sync by freeze bit, frozen plain, and sync with banks open.
        for (int p = 0; p < 4; p++)
        begin
            power_down(p == 1, p != 3, p == 0);
        end
        ctl.tick(20);
        check(39'(notes.size()), 39'h0);
        report_and_stop();
    end

    // The full run takes under a thousand cycles; this limit is about twenty times that.
    initial
    begin
        #80000;
        err_total++;
        report_and_stop();
    end
endmodule : tb
